/* hw/scsa_consts.svh */
// Timing and width constants for the store cycle steal arbiter
`ifndef SCSA_CONSTS_SVH
`define SCSA_CONSTS_SVH
`define SCSA_WORD_W        18
`define SCSA_NUM_CH        4
`define SCSA_ADDR_W        17
`define SCSA_CLK_NS        10
`define SCSA_CYCLE_NS      1200
`define SCSA_CYCLE_CLKS    (`SCSA_CYCLE_NS / `SCSA_CLK_NS)
`define SCSA_CNT_W         8
`define SCSA_LAT_MIN_NS    1500
`define SCSA_LAT_MAX_NS    2700
`define SCSA_LAT_MIN_CLKS  ((`SCSA_LAT_MIN_NS + `SCSA_CLK_NS - 1) / `SCSA_CLK_NS)
`define SCSA_LAT_MAX_CLKS  (`SCSA_LAT_MAX_NS / `SCSA_CLK_NS)
`define SCSA_SETUP_CLKS    (`SCSA_LAT_MIN_CLKS - `SCSA_CYCLE_CLKS - 3)
`define SCSA_AGE_W         5
`define SCSA_PEAK_WPS      833333
`endif

/* hw/scsa_pkg.sv */
// Types for the store cycle steal arbiter
package scsa_pkg;
	typedef enum logic [1:0]
	{
		SCSA_OWN_NONE = 2'b00,
		SCSA_OWN_CPU  = 2'b01,
		SCSA_OWN_CHAN = 2'b10
	} scsa_owner_t;
endpackage

/* hw/scsa_sync2.sv */
// Two-stage synchroniser for channel request pins
`timescale 1ns/100ps
module scsa_sync2
(
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// Async level in, synchronised level out
	input  wire logic async_i,
	output logic      sync_o
);
	logic meta_r;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			meta_r <= 1'b0;
			sync_o <= 1'b0;
		end
		else
		begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule // scsa_sync2

/* hw/scsa_arbiter.sv */
// Store cycle steal arbiter: four channels and the processor share the store
//
// Behaviour
// - Four independent channel ports all sit on the one store data bus.
// - A channel raises its request and receives the next whole store cycle.
// - Simultaneous requests are granted in fixed order, channel 0 highest.
// - The processor gets the store only when no channel request waits.
// - Channel words move by stolen cycles without processor instructions.
// - Each granted channel cycle moves exactly one 18-bit word in or out.
// - Top channel request-to-done latency lies within 1.5 us to 2.7 us.
// - Back-to-back channel cycles sustain the peak word rate.
`timescale 1ns/100ps
`include "scsa_consts.svh"
module scsa_arbiter
(
	// Clock and reset
	input  wire logic                       clk_sys_i,
	input  wire logic                       rst_i,
	// Channel request and transfer lines
	input  wire logic [`SCSA_NUM_CH-1:0]    ch_req_i,
	input  wire logic [`SCSA_NUM_CH-1:0]    ch_wr_i,
	input  wire logic [`SCSA_ADDR_W-1:0]    ch_addr_i [`SCSA_NUM_CH],
	input  wire logic [`SCSA_WORD_W-1:0]    ch_wdata_i [`SCSA_NUM_CH],
	output logic      [`SCSA_NUM_CH-1:0]    ch_gnt_o,
	output logic      [`SCSA_NUM_CH-1:0]    ch_done_o,
	output logic      [`SCSA_WORD_W-1:0]    ch_rdata_o,
	// Processor store port
	input  wire logic                       cpu_req_i,
	input  wire logic                       cpu_wr_i,
	input  wire logic [`SCSA_ADDR_W-1:0]    cpu_addr_i,
	input  wire logic [`SCSA_WORD_W-1:0]    cpu_wdata_i,
	output logic                            cpu_gnt_o,
	output logic                            cpu_done_o,
	output logic      [`SCSA_WORD_W-1:0]    cpu_rdata_o,
	// Shared store data bus
	output logic                            st_start_o,
	output logic                            st_wr_o,
	output logic      [`SCSA_ADDR_W-1:0]    st_addr_o,
	output logic      [`SCSA_WORD_W-1:0]    st_wdata_o,
	input  wire logic [`SCSA_WORD_W-1:0]    st_rdata_i
);
	localparam logic [`SCSA_CNT_W-1:0] CYC_LAST =
		`SCSA_CNT_W'(`SCSA_CYCLE_CLKS - 1);
	localparam logic [`SCSA_AGE_W-1:0] AGE_LAST =
		`SCSA_AGE_W'(`SCSA_SETUP_CLKS);

	logic [`SCSA_NUM_CH-1:0]  req_s;
	logic [`SCSA_NUM_CH-1:0]  pick_nxt;
	logic [`SCSA_CNT_W-1:0]   cnt_r;
	logic [1:0]               sel_r;
	logic [1:0]               sel_nxt;
	logic                     busy_r;
	logic                     wait_any;
	logic [`SCSA_AGE_W-1:0]   age_r [`SCSA_NUM_CH];
	scsa_pkg::scsa_owner_t    own_r;

	// ==========================================================
	// Request synchronisers
	// four ports
	genvar g;
	generate
		for (g = 0; g < `SCSA_NUM_CH; g++)
		begin : g_sync
			scsa_sync2 u_sync
			(
				.clk_sys_i (clk_sys_i),
				.rst_i     (rst_i),
				.async_i   (ch_req_i[g]),
				.sync_o    (req_s[g])
			);
		end
	endgenerate

	// ==========================================================
	// Request ageing
	// minimum latency
	// A request must stand this long before it may win, so even an
	// idle store never finishes a word faster than the lower bound.
	always_ff @(posedge clk_sys_i)
	begin
		for (int i = 0; i < `SCSA_NUM_CH; i++)
		begin
			if (rst_i || !req_s[i] || ch_gnt_o[i])
				age_r[i] <= '0;
			else if (age_r[i] != AGE_LAST)
				age_r[i] <= age_r[i] + 1'b1;
		end
	end

	assign wait_any = |(req_s & ~ch_gnt_o);

	// ==========================================================
	// Fixed priority pick
	// static priority
	always_comb
	begin
		pick_nxt = '0;
		sel_nxt  = 2'b00;
		for (int i = `SCSA_NUM_CH - 1; i >= 0; i--)
		begin
			if (req_s[i] && !ch_gnt_o[i] && age_r[i] == AGE_LAST)
			begin
				pick_nxt = '0;
				pick_nxt[i] = 1'b1;
				sel_nxt = 2'(i);
			end
		end
	end

	// ==========================================================
	// Store cycle sequencer
	// Grants are only taken at a cycle boundary, so a cycle in
	// progress is never cut short by a late request.
	// back to back
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			busy_r <= 1'b0;
			cnt_r  <= '0;
			own_r  <= scsa_pkg::SCSA_OWN_NONE;
			sel_r  <= 2'b00;
		end
		else if (busy_r && cnt_r != CYC_LAST)
		begin
			cnt_r <= cnt_r + 1'b1;
		end
		else if (|pick_nxt)
		begin
			busy_r <= 1'b1;
			cnt_r  <= '0;
			own_r  <= scsa_pkg::SCSA_OWN_CHAN;
			sel_r  <= sel_nxt;
		end
		else if (cpu_req_i && !cpu_gnt_o && !wait_any)
		begin
			busy_r <= 1'b1;
			cnt_r  <= '0;
			own_r  <= scsa_pkg::SCSA_OWN_CPU;
		end
		else
		begin
			busy_r <= 1'b0;
			cnt_r  <= '0;
			own_r  <= scsa_pkg::SCSA_OWN_NONE;
		end
	end

	// ==========================================================
	// Grants held across the cycle
	// grant held
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			ch_gnt_o  <= '0;
			cpu_gnt_o <= 1'b0;
		end
		else if (busy_r && cnt_r != CYC_LAST)
		begin
			ch_gnt_o  <= ch_gnt_o;
			cpu_gnt_o <= cpu_gnt_o;
		end
		else
		begin
			ch_gnt_o  <= pick_nxt;
			cpu_gnt_o <= ~|pick_nxt & cpu_req_i & ~cpu_gnt_o & ~wait_any;
		end
	end

	// ==========================================================
	// Store bus drive
	// steal one cycle
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			st_start_o <= 1'b0;
			st_wr_o    <= 1'b0;
			st_addr_o  <= '0;
			st_wdata_o <= '0;
		end
		else if (!(busy_r && cnt_r != CYC_LAST) && |pick_nxt)
		begin
			st_start_o <= 1'b1;
			st_wr_o    <= ch_wr_i[sel_nxt];
			st_addr_o  <= ch_addr_i[sel_nxt];
			st_wdata_o <= ch_wdata_i[sel_nxt];
		end
		else if (!(busy_r && cnt_r != CYC_LAST) && cpu_req_i && !cpu_gnt_o
			&& !wait_any)
		begin
			st_start_o <= 1'b1;
			st_wr_o    <= cpu_wr_i;
			st_addr_o  <= cpu_addr_i;
			st_wdata_o <= cpu_wdata_i;
		end
		else
		begin
			st_start_o <= 1'b0;
		end
	end

	// ==========================================================
	// Cycle completion and read data
	// one word per cycle
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			ch_done_o   <= '0;
			cpu_done_o  <= 1'b0;
			ch_rdata_o  <= '0;
			cpu_rdata_o <= '0;
		end
		else
		begin
			ch_done_o  <= '0;
			cpu_done_o <= 1'b0;
			if (busy_r && cnt_r == CYC_LAST)
			begin
				if (own_r == scsa_pkg::SCSA_OWN_CHAN)
				begin
					ch_done_o[sel_r] <= 1'b1;
					ch_rdata_o       <= st_rdata_i;
				end
				else if (own_r == scsa_pkg::SCSA_OWN_CPU)
				begin
					cpu_done_o  <= 1'b1;
					cpu_rdata_o <= st_rdata_i;
				end
			end
		end
	end
endmodule // scsa_arbiter

/* tb/scsa_chan_model.sv */
// Channel model that holds its request until granted
`timescale 1ns/100ps
module scsa_chan_model
(
	// Clock, reset, start, grant, request
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic go_i,
	input  wire logic gnt_i,
	output logic      req_o
);
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || gnt_i)
			req_o <= 1'b0;
		else if (go_i)
			req_o <= 1'b1;
	end
endmodule // scsa_chan_model

/* tb/scsa_arbiter_props.sv */
// Port assertions for the store cycle steal arbiter
`timescale 1ns/100ps
`include "scsa_consts.svh"
module scsa_arbiter_props
(
	// Watched ports
	input  wire logic                    clk_sys_i,
	input  wire logic                    rst_i,
	input  wire logic [`SCSA_NUM_CH-1:0] ch_req_i,
	input  wire logic [`SCSA_NUM_CH-1:0] ch_gnt_o,
	input  wire logic [`SCSA_NUM_CH-1:0] ch_done_o,
	input  wire logic                    cpu_gnt_o,
	input  wire logic                    st_start_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	localparam int LAT_LO = `SCSA_LAT_MIN_CLKS;
	localparam int LAT_HI = `SCSA_LAT_MAX_CLKS;
	a_one_owner: assert property ($onehot0({ch_gnt_o, cpu_gnt_o}))
		else $error("two owners");
	a_start_owned: assert property (st_start_o |-> ch_gnt_o || cpu_gnt_o)
		else $error("start unowned");
	a_start_pulse: assert property (st_start_o |=> !st_start_o)
		else $error("long start");
	a_done_ends: assert property (ch_done_o != 0 |->
		ch_done_o == $past(ch_gnt_o) && (ch_gnt_o & ch_done_o) == 0)
		else $error("bad done");
	a_cycle_len: assert property ($rose(ch_gnt_o[0]) |->
		##[118:121] ch_done_o[0])
		else $error("cycle length");
	a_cpu_last: assert property ($rose(cpu_gnt_o) |->
		$past(ch_req_i, 3) == 0)
		else $error("cpu over channel");
	a_fixed_prio: assert property ($rose(ch_gnt_o[1]) |->
		!$past(ch_req_i[0], 3))
		else $error("order");
	a_lat_top: assert property ($rose(ch_req_i[0]) |->
		##[LAT_LO:LAT_HI] ch_done_o[0])
		else $error("latency");
	cover property (ch_done_o[0]);
	cover property ($rose(cpu_gnt_o));
	cover property ($rose(ch_gnt_o[3]));
endmodule // scsa_arbiter_props
bind scsa_arbiter scsa_arbiter_props props_u
(
	.clk_sys_i(clk_sys_i),
	.rst_i(rst_i),
	.ch_req_i(ch_req_i),
	.ch_gnt_o(ch_gnt_o),
	.ch_done_o(ch_done_o),
	.cpu_gnt_o(cpu_gnt_o),
	.st_start_o(st_start_o)
);

/* tb/scsa_arbiter_tb.sv */
// Testbench for the store cycle steal arbiter
`timescale 1ns/100ps
module scsa_arbiter_tb;
	logic        clk_sys_i, rst_i, cpu_req_i, st_start, st_wr, cpu_gnt;
	logic        cpu_done;
	logic [17:0] cpu_rdata;
	logic [3:0]  go, req, wr, gnt, done;
	logic [16:0] addr [4];
	logic [16:0] st_addr;
	logic [17:0] wdata [4];
	logic [17:0] st_rdata, ch_rdata, st_wdata;
	int          err_count, checks;
	scsa_arbiter dut_u
	(
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ch_req_i(req), .ch_wr_i(wr),
		.ch_addr_i(addr), .ch_wdata_i(wdata), .ch_gnt_o(gnt),
		.ch_done_o(done), .ch_rdata_o(ch_rdata), .cpu_req_i(cpu_req_i),
		.cpu_wr_i(1'b0), .cpu_addr_i(17'h0_0000), .cpu_wdata_i(18'h0_0000),
		.cpu_gnt_o(cpu_gnt), .cpu_done_o(cpu_done),
		.cpu_rdata_o(cpu_rdata),
		.st_start_o(st_start), .st_wr_o(st_wr), .st_addr_o(st_addr),
		.st_wdata_o(st_wdata), .st_rdata_i(st_rdata)
	);
	for (genvar i = 0; i < 4; i++)
	begin : g_ch
		scsa_chan_model ch_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
			.go_i(go[i]), .gnt_i(gnt[i]), .req_o(req[i]));
	end
	task automatic chk(input logic [17:0] seen, exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// Bounded wait: 4 means store start, else done of that channel
	task automatic wt(input int s);
		int n;
		n = 0;
		do
			@(negedge clk_sys_i);
		while ((s > 3 ? st_start : done[s]) !== 1'b1 && ++n < 400);
		chk(n < 400, 1, "wait");
	endtask
	task automatic pulse(input logic [3:0] v);
		go = v;
		@(negedge clk_sys_i);
		go = 4'h0;
	endtask
	task automatic t_write;
		wr[0] = 1'b1;
		addr[0] = 17'h1_2345;
		wdata[0] = 18'h2_abcd;
		pulse(4'h1);
		wt(4);
		chk({st_wr, st_addr}, {1'b1, 17'h1_2345}, "addr");
		chk(st_wdata, 18'h2_abcd, "wdata");
		chk(gnt, 4'h1, "gnt");
		wt(0);
	endtask
	task automatic t_read;
		st_rdata = 18'h1_5a5a;
		pulse(4'h4);
		wt(4);
		chk(st_wr, 0, "rd");
		wt(2);
		chk(ch_rdata, 18'h1_5a5a, "rdata");
	endtask
	// Cpu raised late so all channels wait at once
	task automatic t_prio;
		pulse(4'hf);
		repeat (4) @(negedge clk_sys_i);
		cpu_req_i = 1'b1;
		for (int k = 0; k < 5; k++)
		begin
			wt(4);
			chk({cpu_gnt, gnt}, 5'h01 << k, "order");
		end
		cpu_req_i = 1'b0;
		repeat (120) @(negedge clk_sys_i);
		chk(cpu_done, 1, "cpu done");
		chk(cpu_rdata, 18'h1_5a5a, "cpu rdata");
	endtask
	task automatic summarize;
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	initial
	begin
		rst_i = 1'b1;
		cpu_req_i = 1'b0;
		go = 4'h0;
		wr = 4'h0;
		st_rdata = 18'h0_0000;
		addr = '{default: 17'h0_0000};
		wdata = '{default: 18'h0_0000};
		err_count = 0;
		checks = 0;
		repeat (3) @(negedge clk_sys_i);
		rst_i = 1'b0;
		t_write;
		t_read;
		t_prio;
		repeat (130) @(negedge clk_sys_i);
		summarize;
	end
	// Run needs about 1070 cycles
	initial
	begin
		#30000;
		err_count++;
		summarize;
	end
endmodule // scsa_arbiter_tb
